// [src/lnbg_defs.svh]
// Purpose: named offsets, bit positions and reset values of the LIN setup block
// Assumes: included once per compilation unit
// Notes: indirect indices are the values software writes to the address register
`ifndef LNBG_DEFS_SVH
`define LNBG_DEFS_SVH

// Direct SFR selects
`define LNBG_SFR_CFG 2'h0
`define LNBG_SFR_ADDR 2'h1
`define LNBG_SFR_DATA 2'h2

// Indirect register indices
`define LNBG_IDX_CTRL 8'h08
`define LNBG_IDX_STAT 8'h09
`define LNBG_IDX_SIZE 8'h0B
`define LNBG_IDX_DIV 8'h0C
`define LNBG_IDX_MUL 8'h0D

// Node configuration bits
`define LNBG_CFG_EN 7
`define LNBG_CFG_MASTER 6
`define LNBG_CFG_AUTO 5

// Control bits
`define LNBG_CTL_CLR_INT 3
`define LNBG_CTL_CLR_ERR 2

// Size register: checksum type bit
`define LNBG_SIZE_ENH 7

// Multiplier register layout
`define LNBG_MUL_PRE_HI 7
`define LNBG_MUL_PRE_LO 6
`define LNBG_MUL_MUL_HI 5
`define LNBG_MUL_MUL_LO 1
`define LNBG_MUL_DIV8 0

// Status bits
`define LNBG_ST_DONE 0
`define LNBG_ST_IRQ 1
`define LNBG_ST_ERR 2
`define LNBG_ST_CKS 3
`define LNBG_ST_SYNC 4

// Reset values
`define LNBG_RST_BYTE 8'h00
`define LNBG_RST_DIV 9'h000
`define LNBG_RST_CNT 10'h000

// Autobaud: sync field spans 8 bits, 5 falling edges
`define LNBG_SYNC_EDGES 3'h4
`define LNBG_SYNC_SHIFT 3
`define LNBG_SYNC_MAX 10'h100
`define LNBG_MUL_MAX 5'h1F

`endif

// [src/lnbg_pkg.sv]
// Purpose: types shared by the LIN setup and bit-rate block
// Assumes: nothing
// Notes: constants live in lnbg_defs.svh
package lnbg_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } lnbg_sfr_t;

  typedef struct packed {
    logic [1:0] presc;
    logic [4:0] mult;
    logic [8:0] div;
  } lnbg_baud_t;

  typedef enum logic [1:0] {
    LNBG_AB_IDLE = 2'b01,
    LNBG_AB_MEAS = 2'b10
  } lnbg_ab_t;

endpackage

// [src/lnbg_core.sv]
// Purpose: LIN node setup registers, bit-rate generator, autobaud and checksum unit
// Assumes: one clock clk_sys_in, async active-high reset rst_in, byte-wide SFR access
// Notes: frame sequencing lives outside and reports through the event and checksum ports
`include "lnbg_defs.svh"

module lnbg_core
  import lnbg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire lnbg_sfr_t sfr_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic lin_rx_in,
  input wire logic done_evt_in,
  input wire logic err_evt_in,
  input wire logic cks_start_in,
  input wire logic [7:0] cks_pid_in,
  input wire logic cks_byte_vld_in,
  input wire logic [7:0] cks_byte_in,
  input wire logic cks_cmp_vld_in,
  input wire logic [7:0] cks_cmp_in,
  output logic [7:0] cks_value_out,
  output logic bit_tick_out,
  output logic node_en_out,
  output logic master_out,
  output logic enhanced_out,
  output logic irq_out
);

  // Rx pin synchroniser
  logic rx_s1_r, rx_s2_r, rx_d_r;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_d_r <= 1'b1;
    end else begin
      rx_s1_r <= lin_rx_in;
      rx_s2_r <= rx_s1_r;
      rx_d_r <= rx_s2_r;
    end
  end
  logic rx_fall;
  assign rx_fall = rx_d_r & ~rx_s2_r;

  // Registers
  logic [7:0] cfg_r, cfg_nxt, addr_r, addr_nxt, ctrl_r, ctrl_nxt, size_r, size_nxt;
  logic [7:0] divl_r, divl_nxt, mul_r, mul_nxt, rdata_r, rdata_nxt;
  logic done_r, done_nxt, irq_r, irq_nxt, err_r, err_nxt, ckerr_r, ckerr_nxt;
  logic [7:0] stat;
  logic data_wr, data_rd, clr_int, clr_err, cks_bad;
  // Autobaud state, read by the status and baud decode below
  lnbg_ab_t ab_r, ab_nxt;
  logic [9:0] ab_cnt_r, ab_cnt_nxt;
  logic [2:0] ab_edge_r, ab_edge_nxt;
  logic [4:0] ab_mult_r, ab_mult_nxt;
  logic ab_ok_r, ab_ok_nxt;
  logic [6:0] ab_bits;

  function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] idx);
    idx_hit = (a == idx);
  endfunction

  assign data_wr = sfr_in.wr && sfr_in.sel == `LNBG_SFR_DATA;
  assign data_rd = sfr_in.rd && sfr_in.sel == `LNBG_SFR_DATA;
  assign clr_int = data_wr && idx_hit(addr_r, `LNBG_IDX_CTRL) && sfr_in.wdata[`LNBG_CTL_CLR_INT];
  assign clr_err = data_wr && idx_hit(addr_r, `LNBG_IDX_CTRL) && sfr_in.wdata[`LNBG_CTL_CLR_ERR];

  always_comb begin
    stat = `LNBG_RST_BYTE;
    stat[`LNBG_ST_DONE] = done_r;
    stat[`LNBG_ST_IRQ] = irq_r;
    stat[`LNBG_ST_ERR] = err_r;
    stat[`LNBG_ST_CKS] = ckerr_r;
    stat[`LNBG_ST_SYNC] = ab_ok_r;
  end

  always_comb begin
    cfg_nxt = cfg_r;
    addr_nxt = addr_r;
    ctrl_nxt = ctrl_r;
    size_nxt = size_r;
    divl_nxt = divl_r;
    mul_nxt = mul_r;
    rdata_nxt = rdata_r;
    if (sfr_in.wr && sfr_in.sel == `LNBG_SFR_CFG) begin
      cfg_nxt = sfr_in.wdata;
    end else if (sfr_in.wr && sfr_in.sel == `LNBG_SFR_ADDR) begin
      addr_nxt = sfr_in.wdata;
    end else if (data_wr) begin
      if (idx_hit(addr_r, `LNBG_IDX_CTRL)) begin
        // Clear bits act once and never stick
        ctrl_nxt = sfr_in.wdata;
        ctrl_nxt[`LNBG_CTL_CLR_INT] = 1'b0;
        ctrl_nxt[`LNBG_CTL_CLR_ERR] = 1'b0;
      end else if (idx_hit(addr_r, `LNBG_IDX_SIZE)) begin
        size_nxt = sfr_in.wdata;
      end else if (idx_hit(addr_r, `LNBG_IDX_DIV)) begin
        divl_nxt = sfr_in.wdata;
      end else if (idx_hit(addr_r, `LNBG_IDX_MUL)) begin
        mul_nxt = sfr_in.wdata;
      end
    end
    if (sfr_in.rd) begin
      if (sfr_in.sel == `LNBG_SFR_CFG) begin
        rdata_nxt = cfg_r;
      end else if (sfr_in.sel == `LNBG_SFR_ADDR) begin
        rdata_nxt = addr_r;
      end else if (data_rd && idx_hit(addr_r, `LNBG_IDX_CTRL)) begin
        rdata_nxt = ctrl_r;
      end else if (data_rd && idx_hit(addr_r, `LNBG_IDX_STAT)) begin
        rdata_nxt = stat;
      end else if (data_rd && idx_hit(addr_r, `LNBG_IDX_SIZE)) begin
        rdata_nxt = size_r;
      end else if (data_rd && idx_hit(addr_r, `LNBG_IDX_DIV)) begin
        rdata_nxt = divl_r;
      end else if (data_rd && idx_hit(addr_r, `LNBG_IDX_MUL)) begin
        rdata_nxt = mul_r;
      end else begin
        rdata_nxt = `LNBG_RST_BYTE;
      end
    end
    // Set beats clear when both land in one cycle
    done_nxt = done_evt_in | (done_r & ~clr_int);
    irq_nxt = done_evt_in | err_evt_in | cks_bad | (irq_r & ~clr_int);
    err_nxt = err_evt_in | cks_bad | (err_r & ~clr_err);
    ckerr_nxt = cks_bad | (ckerr_r & ~clr_err);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r <= `LNBG_RST_BYTE;
      addr_r <= `LNBG_RST_BYTE;
      ctrl_r <= `LNBG_RST_BYTE;
      size_r <= `LNBG_RST_BYTE;
      divl_r <= `LNBG_RST_BYTE;
      mul_r <= `LNBG_RST_BYTE;
      rdata_r <= `LNBG_RST_BYTE;
      done_r <= 1'b0;
      irq_r <= 1'b0;
      err_r <= 1'b0;
      ckerr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      addr_r <= addr_nxt;
      ctrl_r <= ctrl_nxt;
      size_r <= size_nxt;
      divl_r <= divl_nxt;
      mul_r <= mul_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      irq_r <= irq_nxt;
      err_r <= err_nxt;
      ckerr_r <= ckerr_nxt;
    end
  end

  // Mode decode
  logic en, auto_eff;
  lnbg_baud_t baud;
  assign en = cfg_r[`LNBG_CFG_EN];
  // Autobaud is ignored on a master so a bad setup still runs at the manual rate
  assign auto_eff = cfg_r[`LNBG_CFG_AUTO] & ~cfg_r[`LNBG_CFG_MASTER];
  assign baud.presc = mul_r[`LNBG_MUL_PRE_HI:`LNBG_MUL_PRE_LO];
  assign baud.mult = auto_eff ? ab_mult_r : mul_r[`LNBG_MUL_MUL_HI:`LNBG_MUL_MUL_LO];
  assign baud.div = {mul_r[`LNBG_MUL_DIV8], divl_r};

  // Bit-rate generator
  logic [4:0] pre_r, pre_nxt, mcnt_r, mcnt_nxt;
  logic [8:0] dcnt_r, dcnt_nxt;
  logic [4:0] pre_last;
  logic pre_tc, div_tc, tick_r, tick_nxt;
  assign pre_last = 5'((5'h2 << baud.presc) - 5'h1);
  assign pre_tc = en && pre_r >= pre_last;
  assign div_tc = pre_tc && dcnt_r + 9'h1 >= baud.div;

  always_comb begin
    pre_nxt = pre_tc ? 5'h0 : 5'(pre_r + 5'h1);
    dcnt_nxt = dcnt_r;
    mcnt_nxt = mcnt_r;
    tick_nxt = 1'b0;
    if (pre_tc) begin
      dcnt_nxt = div_tc ? `LNBG_RST_DIV : 9'(dcnt_r + 9'h1);
    end
    if (div_tc) begin
      if (mcnt_r >= baud.mult) begin
        mcnt_nxt = 5'h0;
        tick_nxt = 1'b1;
      end else begin
        mcnt_nxt = 5'(mcnt_r + 5'h1);
      end
    end
    if (!en) begin
      pre_nxt = 5'h0;
      dcnt_nxt = `LNBG_RST_DIV;
      mcnt_nxt = 5'h0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pre_r <= 5'h0;
      dcnt_r <= `LNBG_RST_DIV;
      mcnt_r <= 5'h0;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      dcnt_r <= dcnt_nxt;
      mcnt_r <= mcnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Autobaud: divider periods counted over the 8-bit sync field
  assign ab_bits = ab_cnt_r[9:`LNBG_SYNC_SHIFT];

  always_comb begin
    ab_nxt = ab_r;
    ab_cnt_nxt = ab_cnt_r;
    ab_edge_nxt = ab_edge_r;
    ab_mult_nxt = ab_mult_r;
    ab_ok_nxt = ab_ok_r;
    case (ab_r)
      LNBG_AB_IDLE: begin
        if (en && auto_eff && rx_fall) begin
          ab_nxt = LNBG_AB_MEAS;
          ab_cnt_nxt = `LNBG_RST_CNT;
          ab_edge_nxt = 3'h0;
        end
      end
      LNBG_AB_MEAS: begin
        if (div_tc) begin
          ab_cnt_nxt = 10'(ab_cnt_r + 10'h1);
        end
        if (!en || !auto_eff || ab_cnt_r >= `LNBG_SYNC_MAX) begin
          // Break or noise too long to be a sync field: wait for the next edge
          ab_nxt = LNBG_AB_IDLE;
        end else if (rx_fall) begin
          ab_edge_nxt = 3'(ab_edge_r + 3'h1);
          if (ab_edge_r + 3'h1 == `LNBG_SYNC_EDGES) begin
            ab_nxt = LNBG_AB_IDLE;
            ab_ok_nxt = 1'b1;
            // Truncated, so a fast master rounds toward the shorter bit
            if (ab_bits == 7'h0) begin
              ab_mult_nxt = 5'h0;
            end else if (ab_bits > 7'(`LNBG_MUL_MAX) + 7'h1) begin
              ab_mult_nxt = `LNBG_MUL_MAX;
            end else begin
              ab_mult_nxt = 5'(ab_bits - 7'h1);
            end
          end
        end
      end
      default: ab_nxt = LNBG_AB_IDLE;
    endcase
    if (!auto_eff) begin
      ab_ok_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ab_r <= LNBG_AB_IDLE;
      ab_cnt_r <= `LNBG_RST_CNT;
      ab_edge_r <= 3'h0;
      ab_mult_r <= 5'h0;
      ab_ok_r <= 1'b0;
    end else begin
      ab_r <= ab_nxt;
      ab_cnt_r <= ab_cnt_nxt;
      ab_edge_r <= ab_edge_nxt;
      ab_mult_r <= ab_mult_nxt;
      ab_ok_r <= ab_ok_nxt;
    end
  end

  // Checksum: inverted carry-wrapped sum, PID included when enhanced
  logic [7:0] sum_r, sum_nxt;
  logic [8:0] add;
  logic bad_r, bad_nxt;
  assign add = {1'b0, sum_r} + {1'b0, cks_byte_in};
  assign cks_bad = bad_r;

  always_comb begin
    sum_nxt = sum_r;
    bad_nxt = 1'b0;
    if (cks_start_in) begin
      sum_nxt = size_r[`LNBG_SIZE_ENH] ? cks_pid_in : `LNBG_RST_BYTE;
    end else if (cks_byte_vld_in) begin
      sum_nxt = 8'(add[7:0] + {7'h0, add[8]});
    end
    if (cks_cmp_vld_in) begin
      bad_nxt = (cks_cmp_in != ~sum_r);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sum_r <= `LNBG_RST_BYTE;
      bad_r <= 1'b0;
    end else begin
      sum_r <= sum_nxt;
      bad_r <= bad_nxt;
    end
  end

  assign sfr_rdata_out = rdata_r;
  assign cks_value_out = ~sum_r;
  assign bit_tick_out = tick_r;
  assign node_en_out = cfg_r[`LNBG_CFG_EN];
  assign master_out = cfg_r[`LNBG_CFG_MASTER];
  assign enhanced_out = size_r[`LNBG_SIZE_ENH];
  assign irq_out = irq_r;

endmodule

// [bench/lnbg_core_assertions.sv]
// Purpose: port-level checks of the LIN setup and bit-rate block
// Assumes: bound to lnbg_core; shadows follow the register writes
// Notes: period check skipped in autobaud and after any write
`include "lnbg_defs.svh"
module lnbg_core_assertions
  import lnbg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire lnbg_sfr_t sfr_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic done_evt_in,
  input wire logic err_evt_in,
  input wire logic cks_cmp_vld_in,
  input wire logic bit_tick_out,
  input wire logic node_en_out,
  input wire logic master_out,
  input wire logic enhanced_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic [7:0] idx_r, cfg_r, mul_r, div_r, size_r;
  logic [31:0] gap_r, divv, period;
  logic seen_r, wr_cfg, wr_dat, clr_w;
  assign wr_cfg = sfr_in.wr && sfr_in.sel == `LNBG_SFR_CFG;
  assign wr_dat = sfr_in.wr && sfr_in.sel == `LNBG_SFR_DATA;
  assign clr_w = wr_dat && idx_r == `LNBG_IDX_CTRL && sfr_in.wdata[`LNBG_CTL_CLR_INT];
  // Divider of zero counts as one
  assign divv = ({mul_r[0], div_r} == 9'h000) ? 32'h1 : {23'h0, mul_r[0], div_r};
  assign period = (32'h2 << mul_r[7:6]) * divv * (mul_r[5:1] + 32'h1);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      idx_r <= 8'h00;
      cfg_r <= 8'h00;
      mul_r <= 8'h00;
      div_r <= 8'h00;
      size_r <= 8'h00;
      gap_r <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      if (sfr_in.wr && sfr_in.sel == `LNBG_SFR_ADDR) idx_r <= sfr_in.wdata;
      if (wr_cfg) cfg_r <= sfr_in.wdata;
      if (wr_dat && idx_r == `LNBG_IDX_MUL) mul_r <= sfr_in.wdata;
      if (wr_dat && idx_r == `LNBG_IDX_DIV) div_r <= sfr_in.wdata;
      if (wr_dat && idx_r == `LNBG_IDX_SIZE) size_r <= sfr_in.wdata;
      gap_r <= bit_tick_out ? 32'h1 : gap_r + 32'h1;
      // Autobaud retunes the multiplier without any write
      if (sfr_in.wr || !node_en_out || (cfg_r[5] && !cfg_r[6])) seen_r <= 1'b0;
      else if (bit_tick_out) seen_r <= 1'b1;
    end
  end
  cfg_enable_a: assert property (wr_cfg |=> node_en_out == cfg_r[7])
    else $error("enable does not follow config bit 7");
  cfg_master_a: assert property (wr_cfg |=> master_out == cfg_r[6])
    else $error("master does not follow config bit 6");
  size_enh_a: assert property (wr_dat && idx_r == `LNBG_IDX_SIZE |=> enhanced_out == size_r[7])
    else $error("checksum type does not follow size bit 7");
  event_irq_a: assert property (done_evt_in || err_evt_in |=> irq_out)
    else $error("event did not raise irq");
  irq_clear_a: assert property (clr_w && !done_evt_in && !err_evt_in && !$past(cks_cmp_vld_in) |=> !irq_out)
    else $error("irq not cleared");
  irq_hold_a: assert property (irq_out && !clr_w |=> irq_out)
    else $error("irq dropped without clear");
  tick_off_a: assert property (!node_en_out [*2] |-> !bit_tick_out)
    else $error("tick while disabled");
  tick_pulse_a: assert property (bit_tick_out |=> !bit_tick_out)
    else $error("tick longer than one cycle");
  tick_period_a: assert property (bit_tick_out && seen_r |-> gap_r == period)
    else $error("bit period wrong");
  rd_none_a: assert property (sfr_in.rd && sfr_in.sel == 2'h3 |=> sfr_rdata_out == 8'h00)
    else $error("unselected read not zero");
  cover property (bit_tick_out && seen_r);
  cover property (done_evt_in ##1 irq_out);
  cover property (cks_cmp_vld_in ##2 irq_out);
endmodule

// [bench/lnbg_lin_node.sv]
// Purpose: far LIN node sending a sync field
// Assumes: bus recessive high through pull-up
// Notes: bit time given per call, fast or slow
module lnbg_lin_node (
  output logic lin_rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lin_rx_out = 1'b1;
  // Start bit, 0x55 LSB first, stop bit; released bus floats high
  task automatic send_sync(input int bit_ns);
    logic [9:0] frame;
    frame = {1'b1, 8'h55, 1'b0};
    for (int i = 0; i < 10; i++) begin
      lin_rx_out = frame[i];
      #(bit_ns);
    end
    lin_rx_out = 1'b1;
  endtask
endmodule

// [bench/tb.sv]
// Purpose: self-checking bench of the LIN setup block
// Assumes: 200 MHz clock, inputs driven at falling edge
// Notes: bit periods kept short by small divider values
`include "lnbg_defs.svh"
module tb
  import lnbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  lnbg_sfr_t sfr_in = '{1'b0, 1'b0, 2'h3, 8'h00};
  logic [7:0] sfr_rdata_out, cks_value_out, cks_pid_in = 8'h00, cks_byte_in = 8'h00, cks_cmp_in = 8'h00;
  logic lin_rx_in, done_evt_in = 1'b0, err_evt_in = 1'b0, cks_start_in = 1'b0;
  logic cks_byte_vld_in = 1'b0, cks_cmp_vld_in = 1'b0;
  logic bit_tick_out, node_en_out, master_out, enhanced_out, irq_out;
  int bad_count = 0;
  int total_checks = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  lnbg_core dut_u (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .sfr_in(sfr_in),
    .sfr_rdata_out(sfr_rdata_out),
    .lin_rx_in(lin_rx_in),
    .done_evt_in(done_evt_in),
    .err_evt_in(err_evt_in),
    .cks_start_in(cks_start_in),
    .cks_pid_in(cks_pid_in),
    .cks_byte_vld_in(cks_byte_vld_in),
    .cks_byte_in(cks_byte_in),
    .cks_cmp_vld_in(cks_cmp_vld_in),
    .cks_cmp_in(cks_cmp_in),
    .cks_value_out(cks_value_out),
    .bit_tick_out(bit_tick_out),
    .node_en_out(node_en_out),
    .master_out(master_out),
    .enhanced_out(enhanced_out),
    .irq_out(irq_out)
  );
  lnbg_lin_node node_u (.lin_rx_out(lin_rx_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [1:0] s, input logic [7:0] d);
    @(negedge clk_sys_in);
    sfr_in = '{w, r, s, d};
    @(negedge clk_sys_in);
    sfr_in = '{1'b0, 1'b0, 2'h3, 8'h00};
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, 1'b0, `LNBG_SFR_ADDR, idx);
    bus(1'b1, 1'b0, `LNBG_SFR_DATA, d);
  endtask
  task automatic creg(input logic [7:0] idx, input logic [7:0] exp, input string what);
    bus(1'b1, 1'b0, `LNBG_SFR_ADDR, idx);
    bus(1'b0, 1'b1, `LNBG_SFR_DATA, 8'h00);
    check(sfr_rdata_out, exp, what);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys_in);
    s = 1'b1;
    @(negedge clk_sys_in);
    s = 1'b0;
  endtask
  // First gap after a change may be partial, so callers measure twice
  task automatic tick_gap(output int n);
    int k;
    k = 0;
    while (bit_tick_out !== 1'b1 && k < 9000) begin
      @(negedge clk_sys_in);
      k++;
    end
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (bit_tick_out !== 1'b1 && n < 9000);
  endtask
  task automatic cks_run(input logic [7:0] p, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] exp);
    @(negedge clk_sys_in);
    cks_start_in = 1'b1;
    cks_pid_in = p;
    @(negedge clk_sys_in);
    cks_start_in = 1'b0;
    cks_byte_vld_in = 1'b1;
    cks_byte_in = b0;
    @(negedge clk_sys_in);
    cks_byte_in = b1;
    @(negedge clk_sys_in);
    cks_byte_vld_in = 1'b0;
    check(cks_value_out, exp, "checksum");
  endtask
  task automatic t_reset();
    check(cks_value_out, 8'hFF, "checksum at reset");
    check({node_en_out, master_out, enhanced_out, irq_out}, 4'h0, "levels at reset");
    creg(`LNBG_IDX_MUL, 8'h00, "mul at reset");
    creg(8'h0A, 8'h00, "unmapped read");
    bus(1'b0, 1'b1, 2'h3, 8'h00);
    check(sfr_rdata_out, 8'h00, "no select read");
    $display("test reset done");
  endtask
  task automatic t_cfg();
    bus(1'b1, 1'b0, `LNBG_SFR_CFG, 8'h80);
    check({node_en_out, master_out}, 2'b10, "activate");
    bus(1'b1, 1'b0, `LNBG_SFR_CFG, 8'hC0);
    check({node_en_out, master_out}, 2'b11, "master");
    bus(1'b0, 1'b1, `LNBG_SFR_CFG, 8'h00);
    check(sfr_rdata_out, 8'hC0, "config read");
    $display("test config done");
  endtask
  task automatic t_baud();
    logic [7:0] mv [2] = '{8'h45, 8'h00};
    logic [7:0] dv [2] = '{8'h2C, 8'hC8};
    int pv [2] = '{3600, 400};
    int n;
    for (int i = 0; i < 2; i++) begin
      wreg(`LNBG_IDX_MUL, mv[i]);
      wreg(`LNBG_IDX_DIV, dv[i]);
      creg(`LNBG_IDX_MUL, mv[i], "mul readback");
      creg(`LNBG_IDX_DIV, dv[i], "div readback");
      tick_gap(n);
      tick_gap(n);
      check(n, pv[i], "bit period");
    end
    $display("test baud done");
  endtask
  task automatic t_cks();
    wreg(`LNBG_IDX_SIZE, 8'h80);
    check(enhanced_out, 1'b1, "enhanced");
    cks_run(8'h11, 8'h41, 8'h42, 8'h6B);
    wreg(`LNBG_IDX_SIZE, 8'h00);
    check(enhanced_out, 1'b0, "classic");
    cks_run(8'h11, 8'hF0, 8'h20, 8'hEE);
    cks_cmp_in = 8'hEE;
    pulse(cks_cmp_vld_in);
    repeat (2) @(negedge clk_sys_in);
    check(irq_out, 1'b0, "good checksum");
    cks_cmp_in = 8'h00;
    pulse(cks_cmp_vld_in);
    repeat (2) @(negedge clk_sys_in);
    check(irq_out, 1'b1, "bad checksum");
    creg(`LNBG_IDX_STAT, 8'h0E, "checksum status");
    wreg(`LNBG_IDX_CTRL, 8'h0C);
    check(irq_out, 1'b0, "irq cleared");
    creg(`LNBG_IDX_STAT, 8'h00, "status cleared");
    $display("test checksum done");
  endtask
  task automatic t_flags();
    pulse(done_evt_in);
    check(irq_out, 1'b1, "done irq");
    pulse(err_evt_in);
    creg(`LNBG_IDX_STAT, 8'h07, "done and error");
    wreg(`LNBG_IDX_CTRL, 8'h08);
    creg(`LNBG_IDX_STAT, 8'h04, "irq clear only");
    wreg(`LNBG_IDX_CTRL, 8'h04);
    creg(`LNBG_IDX_STAT, 8'h00, "error clear");
    creg(`LNBG_IDX_CTRL, 8'h00, "clear bits read zero");
    $display("test flags done");
  endtask
  task automatic t_auto();
    int n;
    bus(1'b1, 1'b0, `LNBG_SFR_CFG, 8'hA0);
    wreg(`LNBG_IDX_MUL, 8'h00);
    wreg(`LNBG_IDX_DIV, 8'h04);
    node_u.send_sync(140);
    creg(`LNBG_IDX_STAT, 8'h10, "sync locked");
    tick_gap(n);
    tick_gap(n);
    check(n, 24, "adopted period");
    $display("test autobaud done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_in);
    rst_in = 1'b0;
    t_reset();
    t_cfg();
    t_baud();
    t_cks();
    t_flags();
    t_auto();
    conclude();
  end
  initial begin
    #250000;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
bind lnbg_core lnbg_core_assertions chk_u (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .sfr_in(sfr_in),
  .sfr_rdata_out(sfr_rdata_out),
  .done_evt_in(done_evt_in),
  .err_evt_in(err_evt_in),
  .cks_cmp_vld_in(cks_cmp_vld_in),
  .bit_tick_out(bit_tick_out),
  .node_en_out(node_en_out),
  .master_out(master_out),
  .enhanced_out(enhanced_out),
  .irq_out(irq_out)
);
